// ### hdl/srs_startup_reset_sequencer.sv
// Chip reset combiner and post-reset startup sequencer
`timescale 1ns/1ns
`default_nettype none
module srs_startup_reset_sequencer #(
  parameter int unsigned POR_CYCLES    = srs_pkg::POR_TYP_CYC,
  parameter int unsigned SLEEP_CYCLES  = srs_pkg::SLEEP_MIN_CYC,
  parameter int unsigned CLKREQ_CYCLES = srs_pkg::CLKREQ_CYC,
  parameter int unsigned LPO_EDGES     = srs_pkg::LPO_EDGES_MIN,
  parameter bit          HAS_CLK_REQ   = 1'b1
) (
  // Clock and power-up reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Board side reset and supply
  input  wire logic ext_reset_n_in,
  input  wire logic core_supply_ok_in,
  // Board side clocks and straps
  input  wire logic low_power_clock_in,
  input  wire logic ext_osc_ref_present_in,
  // Reset and sequence status
  output logic      global_reset_out,
  output logic      por_active_out,
  output logic      sleep_out,
  output logic      boot_enable_out,
  // Clock selections
  output logic      ref_use_crystal_out,
  output logic      lpo_use_internal_out,
  // Clock request pin
  output logic      clk_req_out,
  output logic      clk_req_oe_out
);
  localparam int unsigned POR_W = $clog2(POR_CYCLES + 1);
  localparam int unsigned SEQ_W = $clog2(SLEEP_CYCLES + 1);
  localparam int unsigned LPO_W = $clog2(LPO_EDGES + 1);

  // Parameter checks
  if (POR_CYCLES < 1 || SLEEP_CYCLES < 2) begin : g_bad_counts
    $error("srs: counts too small");
  end
  if (CLKREQ_CYCLES < 1 || CLKREQ_CYCLES >= SLEEP_CYCLES) begin : g_bad_req
    $error("srs: clock request must fall inside sleep");
  end
  if (LPO_EDGES < 1) begin : g_bad_lpo
    $error("srs: low-power edge threshold must be positive");
  end

  // ---------------- Power-on reset timer ----------------
  logic [POR_W-1:0] por_cnt;
  logic [POR_W-1:0] next_por_cnt;
  logic             por_active;
  logic             next_por_active;

  // Count while supply is good; any dip restarts the timer
  always_comb begin
    next_por_cnt = por_cnt;
    if (!core_supply_ok_in) begin
      next_por_cnt = '0;
    end else if (por_active) begin
      next_por_cnt = por_cnt + POR_W'(1);
    end
    // Flag registered so the async reset path sees no compare glitches
    next_por_active = (next_por_cnt < POR_W'(POR_CYCLES));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      por_cnt    <= '0;
      por_active <= 1'b1;
    end else begin
      por_cnt    <= next_por_cnt;
      por_active <= next_por_active;
    end
  end

  // ---------------- Reset combination ----------------
  logic raw_rst;
  logic glob_rst;

  // Any of the three sources holds the chip; last to let go releases it
  assign raw_rst = rst_in | ~ext_reset_n_in | por_active;

  // Clean release into the core clock
  srs_reset_sync u_sync (
    .clk_in       (clk_in),
    .raw_rst_in   (raw_rst),
    .sync_rst_out (glob_rst)
  );

  // ---------------- Startup sequence ----------------
  srs_pkg::srs_state_e state;
  srs_pkg::srs_state_e next_state;
  logic [SEQ_W-1:0]    seq_cnt;
  logic [SEQ_W-1:0]    next_seq_cnt;
  logic                clk_req;
  logic                next_clk_req;
  logic                lpo_prev;
  logic [LPO_W-1:0]    lpo_edges;
  logic [LPO_W-1:0]    next_lpo_edges;
  logic                lpo_internal;
  logic                next_lpo_internal;
  logic                ref_crystal;
  logic                next_ref_crystal;
  logic                lpo_edge;

  assign lpo_edge = low_power_clock_in & ~lpo_prev;

  // Sleep timing, clock request and clock choices
  always_comb begin
    next_state        = state;
    next_seq_cnt      = seq_cnt;
    next_clk_req      = clk_req;
    next_lpo_edges    = lpo_edges;
    next_lpo_internal = lpo_internal;
    next_ref_crystal  = ref_crystal;
    case (state)
      srs_pkg::SRS_HOLD: begin
        // Strap tracked while held, frozen at release
        next_ref_crystal = ~ext_osc_ref_present_in;
        next_seq_cnt     = '0;
        next_state       = srs_pkg::SRS_SLEEP;
      end
      srs_pkg::SRS_SLEEP: begin
        next_seq_cnt = seq_cnt + SEQ_W'(1);
        if (HAS_CLK_REQ && seq_cnt == SEQ_W'(CLKREQ_CYCLES - 1)) begin
          next_clk_req = 1'b1;
        end
        if (lpo_edge && lpo_edges < LPO_W'(LPO_EDGES)) begin
          next_lpo_edges = lpo_edges + LPO_W'(1);
        end
        if (seq_cnt == SEQ_W'(SLEEP_CYCLES - 1)) begin
          next_state        = srs_pkg::SRS_RUN;
          next_lpo_internal = (lpo_edges < LPO_W'(LPO_EDGES));
        end
      end
      srs_pkg::SRS_RUN: begin
        next_state = srs_pkg::SRS_RUN;
      end
      default: begin
        next_state = srs_pkg::SRS_HOLD;
      end
    endcase
  end

  // Everything but the strap copy and lpo_prev restarts with global reset
  always_ff @(posedge clk_in) begin
    lpo_prev    <= low_power_clock_in;
    ref_crystal <= next_ref_crystal;
    if (glob_rst) begin
      state        <= srs_pkg::SRS_HOLD;
      seq_cnt      <= '0;
      clk_req      <= 1'b0;
      lpo_edges    <= '0;
      lpo_internal <= 1'b0;
    end else begin
      state        <= next_state;
      seq_cnt      <= next_seq_cnt;
      clk_req      <= next_clk_req;
      lpo_edges    <= next_lpo_edges;
      lpo_internal <= next_lpo_internal;
    end
  end

  // Outputs
  assign global_reset_out     = glob_rst;
  assign por_active_out       = por_active;
  assign sleep_out            = (state == srs_pkg::SRS_SLEEP);
  assign boot_enable_out      = (state == srs_pkg::SRS_RUN);
  assign ref_use_crystal_out  = ref_crystal;
  assign lpo_use_internal_out = lpo_internal;
  assign clk_req_out          = clk_req;
  assign clk_req_oe_out       = HAS_CLK_REQ;

  // ---------------- Checks ----------------
  property p_ext_hold;
    @(posedge clk_in) disable iff (rst_in)
      !ext_reset_n_in |=> ##1 (glob_rst && !boot_enable_out);
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("external reset did not hold startup");

  property p_por_alone;
    @(posedge clk_in) disable iff (rst_in)
      ($fell(por_active) && ext_reset_n_in)[*1] ##1 ext_reset_n_in[*2]
        |=> !glob_rst;
  endproperty
  a_por_alone: assert property (p_por_alone)
    else $error("startup did not follow power-on release");

  property p_either_holds;
    @(posedge clk_in) disable iff (rst_in)
      (por_active || !ext_reset_n_in) |=> glob_rst;
  endproperty
  a_either_holds: assert property (p_either_holds)
    else $error("global reset released while a source asserted");

  property p_por_length;
    @(posedge clk_in) disable iff (rst_in)
      $fell(por_active) |-> $past(por_cnt) == POR_W'(POR_CYCLES - 1);
  endproperty
  a_por_length: assert property (p_por_length)
    else $error("power-on reset length wrong");

  property p_clk_req_time;
    @(posedge clk_in) disable iff (rst_in)
      $rose(clk_req_out) |->
        $past(seq_cnt) == SEQ_W'(CLKREQ_CYCLES - 1) && $past(sleep_out);
  endproperty
  a_clk_req_time: assert property (p_clk_req_time)
    else $error("clock request raised at wrong time");

  property p_sleep_min;
    @(posedge clk_in) disable iff (rst_in)
      $rose(boot_enable_out) |->
        $past(seq_cnt) == SEQ_W'(SLEEP_CYCLES - 1) && $past(sleep_out);
  endproperty
  a_sleep_min: assert property (p_sleep_min)
    else $error("sleep ended early");

  property p_ref_frozen;
    @(posedge clk_in) disable iff (rst_in)
      (state != srs_pkg::SRS_HOLD) && $past(state != srs_pkg::SRS_HOLD)
        |-> $stable(ref_use_crystal_out);
  endproperty
  a_ref_frozen: assert property (p_ref_frozen)
    else $error("reference choice changed after release");

  property p_lpo_choice;
    @(posedge clk_in) disable iff (rst_in)
      $rose(boot_enable_out) |->
        lpo_use_internal_out == ($past(lpo_edges) < LPO_W'(LPO_EDGES));
  endproperty
  a_lpo_choice: assert property (p_lpo_choice)
    else $error("low-power clock choice wrong");

  property p_sync_release;
    @(posedge clk_in) disable iff (rst_in)
      $fell(raw_rst) |-> glob_rst ##1 glob_rst;
  endproperty
  a_sync_release: assert property (p_sync_release)
    else $error("global reset released without two stages");
endmodule
`default_nettype wire

// ### hdl/srs_pkg.sv
// Constants, state codes and reset synchroniser for the startup sequencer
`timescale 1ns/1ns
`default_nettype none
package srs_pkg;
  // Core clock rate
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
  // Times in microseconds, as specified
  localparam int unsigned POR_TYP_US   = 3000;
  localparam int unsigned POR_MIN_US   = 1500;
  localparam int unsigned CLKREQ_US    = 120;
  localparam int unsigned SLEEP_MIN_US = 4200;
  // Cycle counts derived from the times (exact at whole MHz)
  localparam int unsigned POR_TYP_CYC   = POR_TYP_US * CYC_PER_US;
  localparam int unsigned POR_MIN_CYC   = POR_MIN_US * CYC_PER_US;
  localparam int unsigned CLKREQ_CYC    = CLKREQ_US * CYC_PER_US;
  localparam int unsigned SLEEP_MIN_CYC = SLEEP_MIN_US * CYC_PER_US;
  // Low-power clock edges needed to call it present
  localparam int unsigned LPO_EDGES_MIN = 4;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    SRS_HOLD  = 3'h1,
    SRS_SLEEP = 3'h2,
    SRS_RUN   = 3'h4
  } srs_state_e;
endpackage

// Reset synchroniser: asserts at once, releases after two clock edges
module srs_reset_sync (
  // Clock and raw reset
  input  wire logic clk_in,
  input  wire logic raw_rst_in,
  // Synchronised reset, active high
  output logic      sync_rst_out
);
  logic stage1;
  logic stage2;

  // Async assertion loads constants only; release walks two stages
  always_ff @(posedge clk_in or posedge raw_rst_in) begin
    if (raw_rst_in) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
    end else begin
      stage1 <= 1'b0;
      stage2 <= stage1;
    end
  end

  assign sync_rst_out = stage2;
endmodule
`default_nettype wire

// ### verif/srs_board_model.sv
// Board model: reset button, core supply and low-power clock source
`timescale 1ns/1ns
`default_nettype none
module srs_board_model (
  // Bench controls
  input  wire logic hold_reset_in,
  input  wire logic supply_on_in,
  input  wire logic lpo_run_in,
  // Board pins
  output logic      ext_reset_n_out,
  output logic      core_supply_ok_out,
  output var logic  low_power_clock_out
);
  // Button and supply are plain levels
  assign ext_reset_n_out    = ~hold_reset_in;
  assign core_supply_ok_out = supply_on_in;
  // Slow clock toggles every 120 ns on its own timer; still if absent
  initial low_power_clock_out = 1'b0;
  always #120 begin
    if (lpo_run_in) low_power_clock_out = ~low_power_clock_out;
  end
endmodule
`default_nettype wire

// ### verif/tb_startup_reset_sequencer.sv
// Self-checking bench for the startup reset sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_startup_reset_sequencer;
  localparam int POR = 20;
  localparam int SLP = 40;
  localparam int REQ = 5;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hold = 1'b0;
  logic supply = 1'b1;
  logic lpo_run = 1'b1;
  logic strap = 1'b0;
  wire logic ext_n, sup_ok, lpo_clk;
  logic gr, por, slp, boot, xtal, lpo_int, req, req_oe;
  logic req2, oe2, boot2;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  // Clock and hang guard
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      summarize();
    end
  end
  srs_board_model srs_board_model_i (.hold_reset_in(hold),
    .supply_on_in(supply), .lpo_run_in(lpo_run), .ext_reset_n_out(ext_n),
    .core_supply_ok_out(sup_ok), .low_power_clock_out(lpo_clk));
  srs_startup_reset_sequencer #(.POR_CYCLES(POR), .SLEEP_CYCLES(SLP),
    .CLKREQ_CYCLES(REQ), .LPO_EDGES(4), .HAS_CLK_REQ(1'b1))
    srs_startup_reset_sequencer_i (.clk_in(clk_in), .rst_in(rst_in),
    .ext_reset_n_in(ext_n), .core_supply_ok_in(sup_ok),
    .low_power_clock_in(lpo_clk), .ext_osc_ref_present_in(strap),
    .global_reset_out(gr), .por_active_out(por), .sleep_out(slp),
    .boot_enable_out(boot), .ref_use_crystal_out(xtal),
    .lpo_use_internal_out(lpo_int), .clk_req_out(req),
    .clk_req_oe_out(req_oe));
  // Variant without the clock request pin, same board
  srs_startup_reset_sequencer #(.POR_CYCLES(POR), .SLEEP_CYCLES(SLP),
    .CLKREQ_CYCLES(REQ), .LPO_EDGES(4), .HAS_CLK_REQ(1'b0))
    srs_startup_reset_sequencer_nr_i (.clk_in(clk_in), .rst_in(rst_in),
    .ext_reset_n_in(ext_n), .core_supply_ok_in(sup_ok),
    .low_power_clock_in(lpo_clk), .ext_osc_ref_present_in(strap),
    .global_reset_out(), .por_active_out(), .sleep_out(),
    .boot_enable_out(boot2), .ref_use_crystal_out(),
    .lpo_use_internal_out(), .clk_req_out(req2),
    .clk_req_oe_out(oe2));
  // Compare helpers
  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk_int(input string name, input int exp, input int got);
    compares++;
    if (got != exp) begin
      err_count++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Edges until global reset drops, bounded
  task automatic wait_release(output int n);
    n = 0;
    while (gr !== 1'b0 && n < 100) begin
      step(1);
      n++;
    end
  endtask
  // Sleep, clock request and boot timing plus clock choices
  task automatic check_seq(input logic lpo_exp, input logic xtal_exp);
    int k;
    int kreq;
    k = 0;
    kreq = 0;
    step(1);
    chk_bit("sleep_entry", 1'b1, slp);
    while (boot !== 1'b1 && k < 60) begin
      step(1);
      k++;
      if (req === 1'b1 && kreq == 0) kreq = k;
    end
    chk_int("clk_req_delay", REQ, kreq);
    chk_int("sleep_len", SLP, k);
    chk_bit("sleep_end", 1'b0, slp);
    chk_bit("lpo_internal", lpo_exp, lpo_int);
    chk_bit("use_crystal", xtal_exp, xtal);
    chk_bit("noreq_boot", 1'b1, boot2);
    chk_bit("noreq_clk_req", 1'b0, req2);
  endtask
  task automatic t_power_up();
    int n;
    rst_in = 1'b0;
    wait_release(n);
    chk_bit("por_long_enough", 1'b1, n >= POR);
    chk_int("por_release", POR + 2, n);
    chk_bit("clk_req_oe", 1'b1, req_oe);
    chk_bit("noreq_oe", 1'b0, oe2);
    check_seq(1'b0, 1'b1);
    $display("t_power_up done");
  endtask
  task automatic t_ext_hold();
    int n;
    hold = 1'b1;
    #1;
    chk_bit("async_assert", 1'b1, gr);
    step(POR + 40);
    chk_bit("held_global", 1'b1, gr);
    chk_bit("held_boot", 1'b0, boot);
    chk_bit("held_clk_req", 1'b0, req);
    hold = 1'b0;
    wait_release(n);
    chk_int("sync_release", 2, n);
    check_seq(1'b0, 1'b1);
    $display("t_ext_hold done");
  endtask
  task automatic t_no_lpo_dip();
    int n;
    lpo_run = 1'b0;
    strap = 1'b1;
    supply = 1'b0;
    hold = 1'b1;
    step(3);
    chk_bit("dip_por", 1'b1, por);
    chk_bit("dip_global", 1'b1, gr);
    supply = 1'b1;
    // Button let go first, so the power-on timer governs release
    step(5);
    hold = 1'b0;
    wait_release(n);
    chk_int("por_restart", POR - 3, n);
    check_seq(1'b1, 1'b0);
    $display("t_no_lpo_dip done");
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    step(6);
    t_power_up();
    t_ext_hold();
    t_no_lpo_dip();
    summarize();
  end
endmodule
`default_nettype wire
